// *** src/rwc_pkg.sv ***
// rwc_pkg: constants, register map and types of the reset and watchdog controller.
// Assumes one 25 MHz bus clock; analog detectors and fuses arrive as synchronous levels.
//
// How it works
// RULE1 - reset restores registers, then fetch from vector
// RULE2 - any active source forces reset asynchronously; watchdog and supply resets here act on pclk edges
// RULE3 - start-up delay stretches reset after sources
// RULE4 - power-on input resets, rise starts delay
// RULE5 - long external pin low resets without clock
// RULE6 - disable fuse ignores the external pin
// RULE7 - watchdog reset is one-cycle pulse, then delay
// RULE8 - supply flag set below selected level
// RULE9 - supply interrupt when flag set and enabled
// RULE10 - supply flag clears on change, zero, recovery
// RULE11 - supply reset holds until recovery, then start-up
// RULE12 - power-up flag set after supply restored
// RULE13 - watchdog counts 128 kHz oscillator ticks
// RULE14 - watchdog counter clears on kick, disable, reset
// RULE15 - ten periods; expiry in reset mode resets
// RULE16 - watchdog keeps running in sleep modes
// RULE17 - watchdog may interrupt instead of reset
// RULE18 - always-on fuse picks safety level 1 or 2
// RULE19 - level 1: enabling reset mode always accepted
// RULE20 - level 1 disable needs unlock within four cycles
// RULE21 - level 2: always enabled, enable reads one
// RULE22 - level 2: period change needs unlock window
// RULE23 - unlock signature is byte D8 to protect register
// RULE24 - period code doubles from 2048 ticks, max 1001
// RULE25 - combined mode: interrupt first, vector clears, then reset
// RULE26 - reset enable forced while watchdog reset flag set
package rwc_pkg;
  // clock rates and derived counts
  localparam int CLK_HZ         = 25000000;
  localparam int OSC_HZ         = 128000;
  localparam int OSC_DIV        = CLK_HZ / OSC_HZ;
  localparam int STARTUP_US     = 64;
  localparam int STARTUP_CYCLES = (STARTUP_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int WDT_BASE_TICKS = 2048;

  // watchdog and protection values
  localparam logic [3:0] WDT_MAX_SEL    = 4'h9;
  localparam logic [2:0] PROTECT_WINDOW = 3'h4;
  localparam logic [7:0] UNLOCK_SIG     = 8'hD8;

  // register byte offsets
  localparam logic [7:0] WDT_CTRL_OFS    = 8'h00;
  localparam logic [7:0] PROTECT_OFS     = 8'h04;
  localparam logic [7:0] SUPPLY_CTRL_OFS = 8'h08;
  localparam logic [7:0] RESET_FLAGS_OFS = 8'h0C;
  localparam logic [7:0] WDT_KICK_OFS    = 8'h10;

  // field positions
  localparam int WD_IRQ_FLAG_BIT = 7;
  localparam int WD_IRQ_EN_BIT   = 6;
  localparam int WD_PER_HI_BIT   = 5;
  localparam int WD_RST_EN_BIT   = 3;
  localparam int SUP_FLAG_BIT    = 7;
  localparam int SUP_IRQ_EN_BIT  = 6;
  localparam int FLG_POWER_BIT   = 0;
  localparam int FLG_EXT_BIT     = 1;
  localparam int FLG_WD_BIT      = 3;

  // reset values
  localparam logic [7:0] FLAGS_RST = 8'h01;

  // supply monitor level codes
  localparam logic [2:0] SUP_OFF     = 3'h0;
  localparam logic [2:0] SUP_RST_LO  = 3'h1;
  localparam logic [2:0] SUP_RST_HI  = 3'h2;
  localparam logic [2:0] SUP_FLAG_LO = 3'h3;
  localparam logic [2:0] SUP_FLAG_HI = 3'h4;

  typedef enum logic [1:0] {RS_HOLD, RS_COUNT, RS_RUN} rwc_seq_t;
endpackage

// *** src/rwc_top.sv ***
// rwc_top: reset combiner, start-up stretcher, watchdog and supply monitor with APB registers.
// Assumes inputs synchronous to pclk; fuse inputs high mean programmed.
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module rwc_top #(
  parameter int STARTUP_CYCLES = rwc_pkg::STARTUP_CYCLES,
  parameter int WDT_BASE_TICKS = rwc_pkg::WDT_BASE_TICKS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        por_low,
  input  wire logic        ext_reset_n,
  input  wire logic        ext_reset_disable_fuse,
  input  wire logic        watchdog_always_on_fuse,
  input  wire logic        supply_below,
  input  wire logic        wdt_kick,
  input  wire logic        watchdog_irq_ack,
  output logic             sys_reset_n,
  output logic             reset_vector_fetch,
  output logic             wdt_reset_pulse,
  output logic             watchdog_irq,
  output logic             supply_low_irq,
  output logic      [2:0]  supply_level_sel
);
  localparam int CW   = $clog2(WDT_BASE_TICKS) + 10;
  localparam int SCW  = $clog2(STARTUP_CYCLES + 1);
  localparam int DIVW = $clog2(rwc_pkg::OSC_DIV + 1);

  // refuse sizes the counters cannot serve
  if (WDT_BASE_TICKS < 2 || (WDT_BASE_TICKS & (WDT_BASE_TICKS - 1)) != 0) begin : g_chk_wdt
    $error("WDT_BASE_TICKS must be a power of two, at least 2");
  end
  if (STARTUP_CYCLES < 1) begin : g_chk_start
    $error("STARTUP_CYCLES must be at least 1");
  end

  // last count of a period: base ticks doubled per code step
  function automatic logic [CW-1:0] wdt_limit(input logic [3:0] sel);
    wdt_limit = CW'((CW'(WDT_BASE_TICKS) << sel) - CW'(1));
  endfunction

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == rwc_pkg::WDT_CTRL_OFS) || (a == rwc_pkg::PROTECT_OFS) ||
               (a == rwc_pkg::SUPPLY_CTRL_OFS) || (a == rwc_pkg::RESET_FLAGS_OFS) ||
               (a == rwc_pkg::WDT_KICK_OFS);
  endfunction

  // combined asynchronous reset: no clock needed to force it
  logic rst_async_n;
  assign rst_async_n = presetn & ~por_low & // RULE2 RULE4 RULE5 RULE6
                       (ext_reset_n | ext_reset_disable_fuse);

  // ---------------- apb slave ----------------
  logic        pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic [7:0]  rd_byte;
  logic        wr_fire, wr_wdt, wr_prot, wr_sup, wr_flags, wr_kick;
  logic        wd_irq_flag_q, wd_irq_en_q, wd_rst_en_q, wd_rst_en_rd;
  logic [3:0]  wd_per_q;
  logic        sup_flag_q, sup_irq_en_q;
  logic [2:0]  sup_level_q;
  logic [7:0]  flags_q;
  logic        level2;

  assign level2       = watchdog_always_on_fuse; // RULE18
  assign wd_rst_en_rd = wd_rst_en_q | flags_q[rwc_pkg::FLG_WD_BIT] | level2; // RULE21 RULE26

  // read mux, data sit in the low byte
  always_comb begin
    unique case (paddr)
      rwc_pkg::WDT_CTRL_OFS:
        rd_byte = {wd_irq_flag_q, wd_irq_en_q, wd_per_q[3], 1'b0, wd_rst_en_rd, wd_per_q[2:0]};
      rwc_pkg::SUPPLY_CTRL_OFS: rd_byte = {sup_flag_q, sup_irq_en_q, 3'h0, sup_level_q};
      rwc_pkg::RESET_FLAGS_OFS: rd_byte = flags_q;
      default:                  rd_byte = 8'h00;
    endcase
  end

  // one wait state: data and pready are registered in the first access cycle
  always_comb begin
    pready_d  = psel & penable & ~pready_q;
    pslverr_d = pready_d & ~addr_hit(paddr);
    prdata_d  = pready_d ? {24'h000000, rd_byte} : 32'h00000000;
  end

  always_ff @(posedge pclk or negedge rst_async_n) begin
    if (!rst_async_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign prdata  = prdata_q;

  // writes take effect on the edge that completes the access
  assign wr_fire  = psel & penable & pready_q & pwrite;
  assign wr_wdt   = wr_fire & (paddr == rwc_pkg::WDT_CTRL_OFS);
  assign wr_prot  = wr_fire & (paddr == rwc_pkg::PROTECT_OFS);
  assign wr_sup   = wr_fire & (paddr == rwc_pkg::SUPPLY_CTRL_OFS);
  assign wr_flags = wr_fire & (paddr == rwc_pkg::RESET_FLAGS_OFS);
  assign wr_kick  = wr_fire & (paddr == rwc_pkg::WDT_KICK_OFS);

  // ---------------- start-up sequencer ----------------
  rwc_pkg::rwc_seq_t seq_q, seq_d;
  logic [SCW-1:0]    seq_cnt_q, seq_cnt_d;
  logic              sys_rst_n_q, sys_rst_n_d, fetch_q, fetch_d, core_in_rst;
  logic              wd_pulse_q, wd_pulse_d, sup_rst_q;

  assign core_in_rst = ~sys_rst_n_q;

  // synchronous holds restart the count; release only after the full stretch
  always_comb begin
    seq_d     = seq_q;
    seq_cnt_d = seq_cnt_q;
    if (sup_rst_q) begin
      seq_d     = rwc_pkg::RS_HOLD; // RULE11
      seq_cnt_d = '0;
    end else if (wd_pulse_q) begin
      seq_d     = rwc_pkg::RS_COUNT; // RULE7
      seq_cnt_d = '0;
    end else begin
      unique case (seq_q)
        rwc_pkg::RS_HOLD: begin
          seq_d     = rwc_pkg::RS_COUNT;
          seq_cnt_d = '0;
        end
        rwc_pkg::RS_COUNT: begin
          if (seq_cnt_q == SCW'(STARTUP_CYCLES - 1)) begin
            seq_d = rwc_pkg::RS_RUN; // RULE3
          end else begin
            seq_cnt_d = SCW'(seq_cnt_q + 1'b1);
          end
        end
        rwc_pkg::RS_RUN: seq_d = rwc_pkg::RS_RUN;
      endcase
    end
    sys_rst_n_d = (seq_d == rwc_pkg::RS_RUN);
    fetch_d     = (seq_d == rwc_pkg::RS_RUN) && (seq_q != rwc_pkg::RS_RUN); // RULE1
  end

  // async release lands in counting state, so every source gets the stretch
  always_ff @(posedge pclk or negedge rst_async_n) begin
    if (!rst_async_n) begin
      seq_q       <= rwc_pkg::RS_COUNT;
      seq_cnt_q   <= '0;
      sys_rst_n_q <= 1'b0;
      fetch_q     <= 1'b0;
    end else begin
      seq_q       <= seq_d;
      seq_cnt_q   <= seq_cnt_d;
      sys_rst_n_q <= sys_rst_n_d;
      fetch_q     <= fetch_d;
    end
  end

  assign sys_reset_n        = sys_rst_n_q;
  assign reset_vector_fetch = fetch_q;

  // ---------------- oscillator tick divider ----------------
  logic [DIVW-1:0] div_q, div_d;
  logic            tick_q, tick_d;

  // free-running; the watchdog has no sleep gating so it runs in every mode
  always_comb begin
    tick_d = (div_q == DIVW'(rwc_pkg::OSC_DIV - 1)); // RULE13 RULE16
    div_d  = tick_d ? '0 : DIVW'(div_q + 1'b1);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  // ---------------- watchdog ----------------
  logic [CW-1:0] wd_cnt_q, wd_cnt_d;
  logic [2:0]    win_q, win_d;
  logic          wd_irq_flag_d, wd_irq_en_d, wd_rst_en_d, wd_irq_q, wd_irq_d;
  logic [3:0]    wd_per_d, wr_per;
  logic          wd_on, timeout, to_irq, to_rst, win_open, per_ok;

  assign wd_on    = wd_rst_en_rd | wd_irq_en_q;
  assign win_open = (win_q != 3'h0);
  assign wr_per   = {pwdata[rwc_pkg::WD_PER_HI_BIT], pwdata[2:0]};
  assign per_ok   = (wr_per <= rwc_pkg::WDT_MAX_SEL); // RULE24

  // period counter and time-out decision
  always_comb begin
    wd_cnt_d = wd_cnt_q;
    timeout  = 1'b0;
    if (core_in_rst || !wd_on || wdt_kick || wr_kick) begin
      wd_cnt_d = '0; // RULE14
    end else if (tick_q) begin
      if (wd_cnt_q == wdt_limit(wd_per_q)) begin
        wd_cnt_d = '0;
        timeout  = 1'b1; // RULE15 RULE24
      end else begin
        wd_cnt_d = CW'(wd_cnt_q + 1'b1);
      end
    end
    // combined mode: a pending flag means the handler never ran, so reset
    to_irq     = timeout & ~level2 & wd_irq_en_q & // RULE17 RULE25
                 ~(wd_rst_en_rd & wd_irq_flag_q);
    to_rst     = timeout & ~to_irq & (level2 | wd_rst_en_rd); // RULE15 RULE18
    wd_pulse_d = to_rst; // RULE7
  end

  // control bits, protection window and interrupt flag
  always_comb begin
    wd_irq_flag_d = wd_irq_flag_q;
    wd_irq_en_d   = wd_irq_en_q;
    wd_rst_en_d   = wd_rst_en_q;
    wd_per_d      = wd_per_q;
    win_d         = win_open ? 3'(win_q - 1'b1) : 3'h0;
    if (wr_prot && pwdata[7:0] == rwc_pkg::UNLOCK_SIG) begin
      win_d = rwc_pkg::PROTECT_WINDOW; // RULE20 RULE23
    end
    if (wr_wdt) begin
      win_d       = 3'h0; // window is used up by any control write
      wd_irq_en_d = pwdata[rwc_pkg::WD_IRQ_EN_BIT];
      if (pwdata[rwc_pkg::WD_IRQ_FLAG_BIT]) begin
        wd_irq_flag_d = 1'b0;
      end
      if (level2) begin
        if (win_open && per_ok) begin
          wd_per_d = wr_per; // RULE22
        end
      end else begin
        if (per_ok) begin
          wd_per_d = wr_per;
        end
        if (pwdata[rwc_pkg::WD_RST_EN_BIT]) begin
          wd_rst_en_d = 1'b1; // RULE19
        end else if (win_open && !flags_q[rwc_pkg::FLG_WD_BIT]) begin
          wd_rst_en_d = 1'b0; // RULE20 RULE26
        end
      end
    end
    if (watchdog_irq_ack) begin
      wd_irq_en_d   = 1'b0; // RULE25
      wd_irq_flag_d = 1'b0;
    end
    if (to_irq) begin
      wd_irq_flag_d = 1'b1; // set wins over any clear
    end
    if (core_in_rst) begin
      wd_irq_flag_d = 1'b0; // RULE1
      wd_irq_en_d   = 1'b0;
      wd_rst_en_d   = 1'b0;
      wd_per_d      = 4'h0;
      win_d         = 3'h0;
    end
    wd_irq_d = wd_irq_flag_d & wd_irq_en_d;
  end

  always_ff @(posedge pclk or negedge rst_async_n) begin
    if (!rst_async_n) begin
      wd_cnt_q      <= '0;
      win_q         <= 3'h0;
      wd_irq_flag_q <= 1'b0;
      wd_irq_en_q   <= 1'b0;
      wd_rst_en_q   <= 1'b0;
      wd_per_q      <= 4'h0;
      wd_irq_q      <= 1'b0;
      wd_pulse_q    <= 1'b0;
    end else begin
      wd_cnt_q      <= wd_cnt_d;
      win_q         <= win_d;
      wd_irq_flag_q <= wd_irq_flag_d;
      wd_irq_en_q   <= wd_irq_en_d;
      wd_rst_en_q   <= wd_rst_en_d;
      wd_per_q      <= wd_per_d;
      wd_irq_q      <= wd_irq_d;
      wd_pulse_q    <= wd_pulse_d;
    end
  end

  assign watchdog_irq    = wd_irq_q;
  assign wdt_reset_pulse = wd_pulse_q;

  // ---------------- reset cause flags ----------------
  logic [7:0] flags_d;
  logic       por_seen_q;

  // survive every reset but power-up; a cleared bit reads zero until the cause recurs
  always_comb begin
    flags_d = flags_q;
    if (wr_flags) begin
      flags_d[rwc_pkg::FLG_POWER_BIT] = flags_q[rwc_pkg::FLG_POWER_BIT] &
                                        pwdata[rwc_pkg::FLG_POWER_BIT];
      flags_d[rwc_pkg::FLG_EXT_BIT]   = flags_q[rwc_pkg::FLG_EXT_BIT] &
                                        pwdata[rwc_pkg::FLG_EXT_BIT];
      flags_d[rwc_pkg::FLG_WD_BIT]    = flags_q[rwc_pkg::FLG_WD_BIT] &
                                        pwdata[rwc_pkg::FLG_WD_BIT];
    end
    if (por_seen_q && !por_low) begin
      flags_d[rwc_pkg::FLG_POWER_BIT] = 1'b1; // RULE12
    end
    if (!ext_reset_n && !ext_reset_disable_fuse) begin
      flags_d[rwc_pkg::FLG_EXT_BIT] = 1'b1; // RULE6
    end
    if (wd_pulse_q) begin
      flags_d[rwc_pkg::FLG_WD_BIT] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q    <= rwc_pkg::FLAGS_RST;
      por_seen_q <= 1'b0;
    end else begin
      flags_q    <= flags_d;
      por_seen_q <= por_low;
    end
  end

  // ---------------- supply level monitor ----------------
  logic       sup_flag_d, sup_irq_en_d, sup_irq_q, sup_irq_d, sup_rst_d;
  logic [2:0] sup_level_d;
  logic       sup_flag_mode;

  assign sup_flag_mode = (sup_level_q >= rwc_pkg::SUP_FLAG_LO);

  // level kept across core resets so a supply reset can hold and then release
  always_comb begin
    sup_flag_d   = sup_flag_q;
    sup_irq_en_d = sup_irq_en_q;
    sup_level_d  = sup_level_q;
    if (wr_sup) begin
      sup_irq_en_d = pwdata[rwc_pkg::SUP_IRQ_EN_BIT];
      if (pwdata[2:0] <= rwc_pkg::SUP_FLAG_HI) begin
        sup_level_d = pwdata[2:0];
        if (pwdata[2:0] != sup_level_q) begin
          sup_flag_d = 1'b0; // RULE10
        end
      end
      if (!pwdata[rwc_pkg::SUP_FLAG_BIT]) begin
        sup_flag_d = 1'b0; // RULE10
      end
    end
    if (!supply_below) begin
      sup_flag_d = 1'b0; // RULE10
    end
    if (supply_below && sup_flag_mode) begin
      sup_flag_d = 1'b1; // RULE8
    end
    sup_irq_d = sup_flag_d & sup_irq_en_d; // RULE9
    sup_rst_d = supply_below && // RULE11
                (sup_level_q == rwc_pkg::SUP_RST_LO || sup_level_q == rwc_pkg::SUP_RST_HI);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sup_flag_q   <= 1'b0;
      sup_irq_en_q <= 1'b0;
      sup_level_q  <= rwc_pkg::SUP_OFF;
      sup_irq_q    <= 1'b0;
      sup_rst_q    <= 1'b0;
    end else begin
      sup_flag_q   <= sup_flag_d;
      sup_irq_en_q <= sup_irq_en_d;
      sup_level_q  <= sup_level_d;
      sup_irq_q    <= sup_irq_d;
      sup_rst_q    <= sup_rst_d;
    end
  end

  assign supply_low_irq   = sup_irq_q;
  assign supply_level_sel = sup_level_q;

  // ---------------- checks ----------------
  logic [SCW:0] rlow_cnt;

  // counts consecutive cycles of held reset for the stretch check
  always_ff @(posedge pclk or negedge rst_async_n) begin
    if (!rst_async_n) begin
      rlow_cnt <= '0;
    end else if (sys_rst_n_q) begin
      rlow_cnt <= '0;
    end else if (rlow_cnt != {(SCW+1){1'b1}}) begin
      rlow_cnt <= (SCW+1)'(rlow_cnt + 1'b1);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!rst_async_n);

  a_startup_stretch: assert property ($rose(sys_rst_n_q) |-> // RULE3
                                      rlow_cnt >= (SCW+1)'(STARTUP_CYCLES))
    else $error("reset released before the start-up stretch");
  a_wd_pulse_one: assert property (wd_pulse_q |=> !wd_pulse_q ##0 !sys_rst_n_q // RULE7
                                   ##0 seq_cnt_q == '0)
    else $error("watchdog reset pulse not one cycle or count not restarted");
  a_sup_rst_hold: assert property (sup_rst_q |=> !sys_rst_n_q) // RULE11
    else $error("supply reset did not hold the core");
  a_level2_period: assert property (level2 && wr_wdt && !win_open |=> $stable(wd_per_q)) // RULE22
    else $error("period changed without unlock at level 2");
  a_disable_guard: assert property (!level2 && wd_rst_en_q && wr_wdt && !win_open
                                    && !core_in_rst |=> wd_rst_en_q) // RULE20
    else $error("watchdog disabled without unlock");
  a_flag_forces_en: assert property (flags_q[rwc_pkg::FLG_WD_BIT] |-> prdata_d[3] || !pready_d
                                     || paddr != rwc_pkg::WDT_CTRL_OFS) // RULE26
    else $error("reset enable read zero while watchdog reset flag set");
  a_kick_clear: assert property (wdt_kick |=> wd_cnt_q == '0) // RULE14
    else $error("watchdog counter not cleared by kick");
  a_sup_flag_set: assert property (supply_below && sup_flag_mode |=> sup_flag_q ##0 supply_low_irq
                                   == sup_irq_en_q) // RULE8 RULE9
    else $error("supply flag or interrupt wrong while below level");
  a_sup_recover: assert property (!supply_below |=> !sup_flag_q) // RULE10
    else $error("supply flag stayed set after recovery");
  a_irq_ack: assert property (watchdog_irq_ack && !to_irq && sys_rst_n_q |=> !wd_irq_en_q
                              && !wd_irq_flag_q) // RULE25
    else $error("vectoring did not clear watchdog interrupt state");
  a_fetch_after: assert property ($rose(sys_rst_n_q) |-> reset_vector_fetch) // RULE1
    else $error("no vector fetch at reset release");

  c_wd_reset: cover property (wd_pulse_q);
  c_wd_irq: cover property ($rose(watchdog_irq));
  c_release: cover property ($rose(sys_rst_n_q));
  c_sup_flag: cover property ($rose(sup_flag_q));
endmodule

// *** sim/rwc_env.sv ***
// rwc_env: far side of the controller: supply detectors and the external reset pin.
// Assumes the bench calls its tasks; every level changes just after a pclk edge.
`timescale 1ns/1ps
module rwc_env #(
  parameter int POR_MV = 1400
) (
  input  wire logic       pclk,
  input  wire logic [2:0] supply_level_sel,
  output logic            por_low,
  output logic            ext_reset_n,
  output logic            supply_below
);
  int supply_mv = 3300;
  // trip points in millivolts, arbitrary; codes 5..7 never trip
  int thr_mv [8] = '{0, 2000, 2400, 2800, 3100, 0, 0, 0};

  initial begin
    por_low     = 1'b0;
    ext_reset_n = 1'b1;
  end

  // comparator against the level the block selects
  always_comb begin
    supply_below = (thr_mv[supply_level_sel] > supply_mv);
  end

  // detector below the power-on level holds por_low up
  task set_mv(input int mv);
    @(posedge pclk);
    supply_mv <= mv;
    por_low   <= (mv < POR_MV);
  endtask

  // pin level, no pulse filtering on this side
  task set_pin(input logic v);
    @(posedge pclk);
    ext_reset_n <= v;
  endtask
endmodule

// *** sim/test_reset_and_watchdog_control.sv ***
// test_reset_and_watchdog_control: self-checking bench for rwc_top over APB.
// Assumes shortened start-up and watchdog counts; expectations are written into the sequence below.
`timescale 1ns/1ps
module test_reset_and_watchdog_control;
  localparam int SC = 8;
  localparam int TK = 4 * rwc_pkg::OSC_DIV;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready, pslverr, por_low, ext_reset_n, supply_below;
  logic        rdisf;
  logic        aonf;
  logic        wdt_kick;
  logic        irq_ack;
  logic        sys_reset_n, reset_vector_fetch, wdt_reset_pulse, watchdog_irq, supply_low_irq;
  logic [2:0]  lvl;
  logic [31:0] seed = 32'h1018;
  logic [7:0]  r;
  logic        err;
  logic        saw_pulse = 1'b0;
  int          n, m_flags, mismatches = 0, n_checks = 0;

  rwc_top #(.STARTUP_CYCLES(SC), .WDT_BASE_TICKS(4)) u_rwc_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .por_low(por_low), .ext_reset_n(ext_reset_n), .ext_reset_disable_fuse(rdisf),
    .watchdog_always_on_fuse(aonf), .supply_below(supply_below), .wdt_kick(wdt_kick),
    .watchdog_irq_ack(irq_ack), .sys_reset_n(sys_reset_n),
    .reset_vector_fetch(reset_vector_fetch), .wdt_reset_pulse(wdt_reset_pulse),
    .watchdog_irq(watchdog_irq), .supply_low_irq(supply_low_irq), .supply_level_sel(lvl));
  rwc_env u_rwc_env (.pclk(pclk), .supply_level_sel(lvl), .por_low(por_low),
    .ext_reset_n(ext_reset_n), .supply_below(supply_below));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // sticky record of watchdog reset pulses
  always @(posedge pclk) if (wdt_reset_pulse === 1'b1) saw_pulse <= 1'b1;

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one APB transfer; upper data bits are random noise the block must ignore
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    int k;
    x = rnd();
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {x[31:8], d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    chk(k < 20, 1'b1);
    r = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(r, e);
  endtask

  // wait for pulse (0), irq (1) or core running (2), bounded
  task wait_for(input int s, input int lim);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end
    while (!((s == 0 && wdt_reset_pulse === 1'b1) || (s == 1 && watchdog_irq === 1'b1) ||
             (s == 2 && sys_reset_n === 1'b1)) && n < lim);
    chk(n < lim, 1'b1);
  endtask

  task end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #(40 * 30000);
    mismatches++;
    end_of_test();
  end

  initial begin
    presetn  <= 1'b0;
    psel     <= 1'b0;
    penable  <= 1'b0;
    pwrite   <= 1'b0;
    paddr    <= 8'h00;
    pwdata   <= 32'h00000000;
    rdisf    <= 1'b0;
    aonf     <= 1'b0;
    wdt_kick <= 1'b0;
    irq_ack  <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    m_flags = 1;
    wait_for(2, 100);
    rdc(rwc_pkg::RESET_FLAGS_OFS, m_flags[7:0]);
    rdc(rwc_pkg::WDT_CTRL_OFS, 8'h00);
    rdc(8'h14, 8'h00);
    chk(err, 1'b1);
    // supply flag, interrupt and recovery
    wr(rwc_pkg::SUPPLY_CTRL_OFS, 8'h43);
    u_rwc_env.set_mv(2700);
    repeat (3) @(posedge pclk);
    rdc(rwc_pkg::SUPPLY_CTRL_OFS, 8'hC3);
    chk(lvl, 32'h00000003);
    chk(supply_low_irq, 1'b1);
    u_rwc_env.set_mv(3300);
    repeat (3) @(posedge pclk);
    rdc(rwc_pkg::SUPPLY_CTRL_OFS, 8'h43);
    // supply monitor set up for reset
    wr(rwc_pkg::SUPPLY_CTRL_OFS, 8'h01);
    u_rwc_env.set_mv(1900);
    repeat (4) @(posedge pclk);
    chk(sys_reset_n, 1'b0);
    u_rwc_env.set_mv(3300);
    wait_for(2, 100);
    chk(n > SC, 1'b1);
    wr(rwc_pkg::SUPPLY_CTRL_OFS, 8'h07);
    rdc(rwc_pkg::SUPPLY_CTRL_OFS, 8'h01);
    wr(rwc_pkg::SUPPLY_CTRL_OFS, 8'h00);
    // power-on detector, asynchronous; power-up flag cleared first so it must be set again
    wr(rwc_pkg::RESET_FLAGS_OFS, 8'h00);
    u_rwc_env.set_mv(1000);
    #1 chk(sys_reset_n, 1'b0);
    u_rwc_env.set_mv(3300);
    wait_for(2, 100);
    apb(1'b0, rwc_pkg::RESET_FLAGS_OFS, 8'h00);
    chk(r[0], 1'b1);
    // external pin, then ignored under the disable fuse
    u_rwc_env.set_pin(1'b0);
    #1 chk(sys_reset_n, 1'b0);
    repeat (3) @(posedge pclk);
    u_rwc_env.set_pin(1'b1);
    wait_for(2, 100);
    apb(1'b0, rwc_pkg::RESET_FLAGS_OFS, 8'h00);
    chk(r[1], 1'b1);
    rdisf <= 1'b1;
    u_rwc_env.set_pin(1'b0);
    repeat (5) @(posedge pclk);
    chk(sys_reset_n, 1'b1);
    u_rwc_env.set_pin(1'b1);
    rdisf <= 1'b0;
    wr(rwc_pkg::RESET_FLAGS_OFS, 8'h00);
    m_flags = 0;
    // interrupt-only mode at code 1, doubled period, vector clears
    wr(rwc_pkg::WDT_CTRL_OFS, 8'h41);
    wait_for(1, 3 * TK);
    chk(n > 7 * rwc_pkg::OSC_DIV && n <= 8 * rwc_pkg::OSC_DIV + 1, 1'b1);
    @(posedge pclk) irq_ack <= 1'b1;
    @(posedge pclk) irq_ack <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(watchdog_irq, 1'b0);
    // kicks keep the reset-mode watchdog quiet
    wr(rwc_pkg::WDT_CTRL_OFS, 8'h08);
    wr(rwc_pkg::WDT_CTRL_OFS, 8'h2F);
    rdc(rwc_pkg::WDT_CTRL_OFS, 8'h08);
    for (int i = 0; i < 4; i++) begin
      repeat (TK / 2) @(posedge pclk);
      wdt_kick <= 1'b1;
      @(posedge pclk) wdt_kick <= 1'b0;
    end
    chk(saw_pulse, 1'b0);
    // combined mode: interrupt first, then a one-cycle reset pulse
    wr(rwc_pkg::WDT_CTRL_OFS, 8'h48);
    wait_for(1, 2 * TK);
    chk(saw_pulse, 1'b0);
    wait_for(0, 2 * TK);
    n = 0;
    do begin @(posedge pclk); n++; end while (sys_reset_n !== 1'b1 && n < 50);
    chk(n, SC + 1);
    chk(reset_vector_fetch, 1'b1);
    m_flags = m_flags | 8;
    rdc(rwc_pkg::RESET_FLAGS_OFS, m_flags[7:0]);
    wr(rwc_pkg::PROTECT_OFS, rwc_pkg::UNLOCK_SIG);
    wr(rwc_pkg::WDT_CTRL_OFS, 8'h00);
    rdc(rwc_pkg::WDT_CTRL_OFS, 8'h08);
    wr(rwc_pkg::RESET_FLAGS_OFS, 8'h00);
    wr(rwc_pkg::WDT_CTRL_OFS, 8'h08);
    wr(rwc_pkg::WDT_CTRL_OFS, 8'h00);
    rdc(rwc_pkg::WDT_CTRL_OFS, 8'h08);
    wr(rwc_pkg::PROTECT_OFS, rwc_pkg::UNLOCK_SIG);
    wr(rwc_pkg::WDT_CTRL_OFS, 8'h00);
    rdc(rwc_pkg::WDT_CTRL_OFS, 8'h00);
    // safety level 2: always on, period needs the unlock
    aonf <= 1'b1;
    rdc(rwc_pkg::WDT_CTRL_OFS, 8'h08);
    wr(rwc_pkg::WDT_CTRL_OFS, 8'h01);
    rdc(rwc_pkg::WDT_CTRL_OFS, 8'h08);
    wr(rwc_pkg::PROTECT_OFS, rwc_pkg::UNLOCK_SIG);
    wr(rwc_pkg::WDT_CTRL_OFS, 8'h01);
    rdc(rwc_pkg::WDT_CTRL_OFS, 8'h09);
    wait_for(0, 3 * TK);
    end_of_test();
  end
endmodule
